// file: rtl/ts1_status_one.sv
/*
  Status register bank of a contactless transceiver with APB access,
  event interrupt and the carrier frequency checker.
  Assumes synchronous status inputs from the neighbouring units.
*/
// Local design decision: the APB interface to the registers.
// Contract
// - After reset: result-zero 1, done 0, irq 0, field 0, nearly-full 1.
// - Frequency flag is 1 when carrier lies strictly between 12 and 15 MHz.
// - Frequency flag is unspecified in the guard bands 9-12 and 15-19 MHz.
// - Result-zero flag is 1 when checksum result is zero.
// - Result-zero drops during a calculation, rises when it completes well.
// - Done flag sets when a compute-command calculation finishes.
// - Irq flag is 1 when any enabled interrupt source is active.
// - Timer flag is 1 while the timer unit runs.
// - Field flag follows live field detection, no latching.
// - Nearly-full is 1 when 64 minus fill count is at most threshold.
// - Nearly-empty is 1 when fill count is at most threshold.
// - Check-failed sets on receive checksum failure if enabled; clears at rx start.
`include "ts1_params.svh"
`default_nettype none
module ts1_status_one
  import ts1_pkg::*;
#(
  parameter int COMM_W = 7,
  parameter int MISC_W = 5,
  parameter int WIN_NS = `TS1_FREQ_WIN_NS
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rst,
  input  wire logic              i_psel,
  input  wire logic              i_penable,
  input  wire logic              i_pwrite,
  input  wire logic [7:0]        i_paddr,
  input  wire logic [31:0]       i_pwdata,
  output logic                   o_pready,
  output logic [31:0]            o_prdata,
  output logic                   o_pslverr,
  input  wire logic              i_rx_carrier,
  input  wire logic              i_crc_start,
  input  wire logic              i_crc_compute_cmd,
  input  wire logic              i_crc_finish,
  input  wire logic              i_crc_residue_zero,
  input  wire logic [COMM_W-1:0] i_comm_irq_src,
  input  wire logic [MISC_W-1:0] i_misc_irq_src,
  input  wire logic              i_timer_enabled,
  input  wire logic              i_field_detect,
  input  wire logic [6:0]        i_fifo_fill_count,
  input  wire logic              i_rx_start,
  input  wire logic              i_rx_crc_fail,
  output logic [7:0]             o_status_one,
  output logic                   o_checksum_check_failed,
  output logic                   o_irq
);
  ////////////////////////////////////////////////////////////////////
  // Declarations
  ts1_freq_if freq ();

  ts1_status_s          st_q;
  ts1_crc_e             crc_q;
  ts1_crc_e             crc_d;
  logic                 crcz_q;
  logic [5:0]           thr_q;
  logic [COMM_W-1:0]    comm_ien_q;
  logic [MISC_W-1:0]    misc_ien_q;
  logic                 rx_crc_en_q;
  logic                 fail_q;
  logic [`TS1_EV_W-1:0] ev_stat_q;
  logic [`TS1_EV_W-1:0] ev_mask_q;
  logic [`TS1_EV_W-1:0] ev_set;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  logic [31:0]          rd_mux;
  logic                 rd_hit;
  logic                 wr_en;
  logic [5:0]           idx;
  logic                 nfull_now;
  logic                 nempty_now;
  logic                 irq_now;

  ////////////////////////////////////////////////////////////////////
  // Carrier checker
  ts1_freq_check #(
    .WIN_NS (WIN_NS)
  ) u_freq (
    .i_mclk       (i_mclk),
    .i_rst        (i_rst),
    .i_rx_carrier (i_rx_carrier),
    .freq         (freq.src)
  );

  ////////////////////////////////////////////////////////////////////
  // Checksum co-processor tracking
  always_comb begin
    crc_d = crc_q;
    case (crc_q)
      TS1_CRC_IDLE,
      TS1_CRC_DONE: begin
        if (i_crc_start) begin
          crc_d = TS1_CRC_BUSY;
        end
      end
      TS1_CRC_BUSY: begin
        if (i_crc_finish) begin
          crc_d = i_crc_compute_cmd ? TS1_CRC_DONE : TS1_CRC_IDLE;
        end
      end
      default: crc_d = TS1_CRC_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      crc_q <= TS1_CRC_IDLE;
    end else begin
      crc_q <= crc_d;
    end
  end

  // Zero while busy, result once finished
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      crcz_q <= 1'(`TS1_STATUS_RST >> `TS1_B_CRCZ);
    end else if (crc_q == TS1_CRC_BUSY && i_crc_finish) begin
      crcz_q <= i_crc_residue_zero;
    end else if (crc_d == TS1_CRC_BUSY) begin
      crcz_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Live flags
  assign nfull_now  = (7'(`TS1_FIFO_DEPTH) - i_fifo_fill_count) <= {1'b0, thr_q};
  assign nempty_now = i_fifo_fill_count <= {1'b0, thr_q};
  assign irq_now    = |(i_comm_irq_src & comm_ien_q) | |(i_misc_irq_src & misc_ien_q);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      st_q <= ts1_status_s'(`TS1_STATUS_RST);
    end else begin
      if (freq.measure_valid) begin
        st_q.carrier_freq_in_range <= freq.in_range;
      end
      st_q.checksum_result_zero <= crcz_q;
      st_q.checksum_done        <= (crc_q == TS1_CRC_DONE);
      st_q.irq_pending          <= irq_now;
      st_q.timer_active         <= i_timer_enabled;
      st_q.field_present        <= i_field_detect;
      st_q.fifo_nearly_full     <= nfull_now;
      st_q.fifo_nearly_empty    <= nempty_now;
    end
  end

  assign o_status_one = st_q;

  // Receive checksum failure, set wins over rx-start clear
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      fail_q <= 1'b0;
    end else if (i_rx_crc_fail && rx_crc_en_q) begin
      fail_q <= 1'b1;
    end else if (i_rx_start) begin
      fail_q <= 1'b0;
    end
  end

  assign o_checksum_check_failed = fail_q;

  ////////////////////////////////////////////////////////////////////
  // APB slave, one wait-free access phase, data registered in setup
  assign idx   = i_paddr[7:2];
  assign wr_en = i_psel && i_penable && i_pwrite;

  always_comb begin
    rd_mux = '0;
    rd_hit = 1'b1;
    case (idx)
      6'(`TS1_IDX_STATUS_ONE): rd_mux[7:0]        = st_q;
      6'(`TS1_IDX_THRESHOLD):  rd_mux[5:0]        = thr_q;
      6'(`TS1_IDX_COMM_IEN):   rd_mux[COMM_W-1:0] = comm_ien_q;
      6'(`TS1_IDX_MISC_IEN):   rd_mux[MISC_W-1:0] = misc_ien_q;
      6'(`TS1_IDX_CONTROL):    rd_mux[`TS1_B_RX_CRC_EN] = rx_crc_en_q;
      6'(`TS1_IDX_ERROR):      rd_mux[`TS1_B_CRC_FAIL]  = fail_q;
      6'(`TS1_IDX_EVT_STAT):   rd_mux[`TS1_EV_W-1:0]    = ev_stat_q;
      6'(`TS1_IDX_EVT_MASK):   rd_mux[`TS1_EV_W-1:0]    = ev_mask_q;
      default:                 rd_hit = 1'b0;
    endcase
    if (i_paddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      prdata_q  <= '0;
      pslverr_q <= 1'b0;
    end else if (i_psel && !i_penable) begin
      prdata_q  <= i_pwrite ? 32'h0 : rd_mux;
      pslverr_q <= !rd_hit;
    end
  end

  assign o_pready  = i_psel && i_penable;
  assign o_prdata  = (i_psel && i_penable) ? prdata_q : 32'h0;
  assign o_pslverr = (i_psel && i_penable) ? pslverr_q : 1'b0;

  // Writable configuration; status one has no write path
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      thr_q       <= '0;
      comm_ien_q  <= '0;
      misc_ien_q  <= '0;
      rx_crc_en_q <= 1'b0;
      ev_mask_q   <= '0;
    end else if (wr_en && rd_hit) begin
      case (idx)
        6'(`TS1_IDX_THRESHOLD): thr_q      <= i_pwdata[5:0];
        6'(`TS1_IDX_COMM_IEN):  comm_ien_q <= i_pwdata[COMM_W-1:0];
        6'(`TS1_IDX_MISC_IEN):  misc_ien_q <= i_pwdata[MISC_W-1:0];
        6'(`TS1_IDX_CONTROL):   rx_crc_en_q <= i_pwdata[`TS1_B_RX_CRC_EN];
        6'(`TS1_IDX_EVT_MASK):  ev_mask_q  <= i_pwdata[`TS1_EV_W-1:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Event interrupt, set wins over write-one-to-clear
  always_comb begin
    ev_set                = '0;
    ev_set[`TS1_EV_FIELD] = i_field_detect && !st_q.field_present;
    ev_set[`TS1_EV_CRCD]  = (crc_d == TS1_CRC_DONE) && (crc_q != TS1_CRC_DONE);
    ev_set[`TS1_EV_NFULL] = nfull_now && !st_q.fifo_nearly_full;
    ev_set[`TS1_EV_FAIL]  = i_rx_crc_fail && rx_crc_en_q;
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      ev_stat_q <= '0;
    end else if (wr_en && idx == 6'(`TS1_IDX_EVT_STAT) && i_paddr[1:0] == 2'h0) begin
      ev_stat_q <= (ev_stat_q & ~i_pwdata[`TS1_EV_W-1:0]) | ev_set;
    end else begin
      ev_stat_q <= ev_stat_q | ev_set;
    end
  end

  assign o_irq = |(ev_stat_q & ev_mask_q);

  ////////////////////////////////////////////////////////////////////
  // Assertions
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  AST_RESET_VALUE: assert property (
    $past(i_rst) |->
      o_status_one[`TS1_B_CRCZ] && !o_status_one[`TS1_B_CRCD] &&
      !o_status_one[`TS1_B_IRQ] && !o_status_one[`TS1_B_FIELD] &&
      o_status_one[`TS1_B_NFULL])
    else $error("status one wrong after reset");

  AST_FREQ_FOLLOW: assert property (
    freq.measure_valid |=> o_status_one[`TS1_B_FREQ] == $past(freq.in_range))
    else $error("frequency flag not updated from measurement");

  AST_CRC_ZERO_BUSY: assert property (
    (crc_q == TS1_CRC_BUSY && !i_crc_finish) |=> ##1 !o_status_one[`TS1_B_CRCZ])
    else $error("result-zero flag high during calculation");

  AST_CRC_ZERO_RESULT: assert property (
    (crc_q == TS1_CRC_BUSY && i_crc_finish && !i_crc_start)
      |=> ##1 o_status_one[`TS1_B_CRCZ] == $past(i_crc_residue_zero, 2))
    else $error("result-zero flag does not show result");

  AST_CRC_DONE: assert property (
    (crc_q == TS1_CRC_BUSY && i_crc_finish && i_crc_compute_cmd)
      |=> ##1 o_status_one[`TS1_B_CRCD])
    else $error("done flag missing after compute");

  AST_IRQ_PENDING: assert property (
    !$past(i_rst) |-> o_status_one[`TS1_B_IRQ] ==
      (|($past(i_comm_irq_src) & $past(comm_ien_q)) ||
       |($past(i_misc_irq_src) & $past(misc_ien_q))))
    else $error("interrupt pending flag wrong");

  AST_TIMER: assert property (
    !$past(i_rst) |-> o_status_one[`TS1_B_TMR] == $past(i_timer_enabled))
    else $error("timer flag does not follow enable");

  AST_FIELD_LIVE: assert property (
    !i_field_detect |=> !o_status_one[`TS1_B_FIELD])
    else $error("field flag latched");

  AST_NEAR_FULL: assert property (
    !$past(i_rst) |-> o_status_one[`TS1_B_NFULL] ==
      ((7'(`TS1_FIFO_DEPTH) - $past(i_fifo_fill_count)) <= {1'b0, $past(thr_q)}))
    else $error("nearly-full flag wrong");

  AST_NEAR_EMPTY: assert property (
    !$past(i_rst) |->
      o_status_one[`TS1_B_NEMPTY] == ($past(i_fifo_fill_count) <= {1'b0, $past(thr_q)}))
    else $error("nearly-empty flag wrong");

  AST_FAIL_SET: assert property (
    (i_rx_crc_fail && rx_crc_en_q) |=> o_checksum_check_failed)
    else $error("check-failed flag not set");

  AST_FAIL_CLEAR: assert property (
    (i_rx_start && !(i_rx_crc_fail && rx_crc_en_q)) |=> !o_checksum_check_failed)
    else $error("check-failed flag not cleared at rx start");

  AST_RO_WRITE: assert property (
    (wr_en && idx == 6'(`TS1_IDX_STATUS_ONE)) |=> $stable(thr_q) && $stable(ev_mask_q))
    else $error("write to status one changed state");

  AST_EVT_SET_WINS: assert property (
    (|ev_set) |=> (ev_stat_q & $past(ev_set)) == $past(ev_set))
    else $error("event status bit lost");

  COV_CRC_DONE: cover property (crc_q == TS1_CRC_BUSY ##1 crc_q == TS1_CRC_DONE);
  COV_IN_RANGE: cover property (freq.measure_valid && freq.in_range);
  COV_NFULL_IRQ: cover property (ev_set[`TS1_EV_NFULL] ##1 o_irq);
  COV_W1C: cover property (wr_en && idx == 6'(`TS1_IDX_EVT_STAT));
endmodule
`default_nettype wire

// file: rtl/ts1_params.svh
/*
  Constants of the transceiver status block: offsets, bit positions,
  reset values and timing figures.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef TS1_PARAMS_SVH
`define TS1_PARAMS_SVH
// Register indices, byte address is four times the index
`define TS1_IDX_STATUS_ONE 8'h07
`define TS1_IDX_THRESHOLD  8'h10
`define TS1_IDX_COMM_IEN   8'h11
`define TS1_IDX_MISC_IEN   8'h12
`define TS1_IDX_CONTROL    8'h13
`define TS1_IDX_ERROR      8'h14
`define TS1_IDX_EVT_STAT   8'h15
`define TS1_IDX_EVT_MASK   8'h16
// Status one bit positions
`define TS1_B_FREQ   7
`define TS1_B_CRCZ   6
`define TS1_B_CRCD   5
`define TS1_B_IRQ    4
`define TS1_B_TMR    3
`define TS1_B_FIELD  2
`define TS1_B_NFULL  1
`define TS1_B_NEMPTY 0
`define TS1_STATUS_RST 8'h42
// Control and error bits
`define TS1_B_RX_CRC_EN 0
`define TS1_B_CRC_FAIL  0
// Event bits
`define TS1_EV_FIELD 0
`define TS1_EV_CRCD  1
`define TS1_EV_NFULL 2
`define TS1_EV_FAIL  3
`define TS1_EV_W     4
`define TS1_FIFO_DEPTH 64
// Carrier window and limits
`define TS1_CLK_NS      20
`define TS1_FREQ_WIN_NS 20000
`define TS1_FREQ_LO_MHZ 12
`define TS1_FREQ_HI_MHZ 15
`endif

// file: rtl/ts1_pkg.sv
/*
  Types of the transceiver status block.
  Assumes ts1_params.svh for the numbers.
*/
`default_nettype none
package ts1_pkg;
  typedef enum logic [2:0] {
    TS1_CRC_IDLE = 3'b001,
    TS1_CRC_BUSY = 3'b010,
    TS1_CRC_DONE = 3'b100
  } ts1_crc_e;
  typedef struct packed {
    logic carrier_freq_in_range;
    logic checksum_result_zero;
    logic checksum_done;
    logic irq_pending;
    logic timer_active;
    logic field_present;
    logic fifo_nearly_full;
    logic fifo_nearly_empty;
  } ts1_status_s;
endpackage
`default_nettype wire

// file: rtl/ts1_freq_if.sv
/*
  Carrier measurement result passed from the frequency checker to the
  status block.
  Assumes both ends on the same clock.
*/
`default_nettype none
interface ts1_freq_if;
  logic measure_valid;
  logic in_range;
  modport src (output measure_valid, output in_range);
  modport dst (input  measure_valid, input  in_range);
endinterface
`default_nettype wire

// file: rtl/ts1_freq_check.sv
/*
  Counts rising edges of the receive carrier over a fixed window and
  reports whether the frequency lies inside the accepted band.
  Assumes the carrier input is synchronous to i_mclk.
*/
`include "ts1_params.svh"
`default_nettype none
module ts1_freq_check
  import ts1_pkg::*;
#(
  parameter int WIN_NS = `TS1_FREQ_WIN_NS
) (
  input  wire logic i_mclk,
  input  wire logic i_rst,
  input  wire logic i_rx_carrier,
  ts1_freq_if.src   freq
);
  localparam int WIN_CYC = WIN_NS / `TS1_CLK_NS;
  localparam int LO_EDG  = `TS1_FREQ_LO_MHZ * WIN_NS / 1000;
  localparam int HI_EDG  = `TS1_FREQ_HI_MHZ * WIN_NS / 1000;
  localparam int CW      = $clog2(WIN_CYC + 1);

  logic [CW-1:0] win_q;
  logic [CW-1:0] edges_q;
  logic          prev_q;
  logic          win_end;
  logic          edge_now;
  logic [CW-1:0] edges_tot;

  assign win_end   = (win_q == CW'(WIN_CYC - 1));
  // Edge in the closing cycle still belongs to the window
  assign edge_now  = i_rx_carrier && !prev_q;
  assign edges_tot = edges_q + CW'(edge_now);

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      win_q  <= '0;
      prev_q <= 1'b0;
    end else begin
      prev_q <= i_rx_carrier;
      win_q  <= win_end ? '0 : win_q + 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst || win_end) begin
      edges_q <= '0;
    end else if (edge_now) begin
      edges_q <= edges_q + 1'b1;
    end
  end

  // Strict band; inside the guard bands either answer is acceptable
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      freq.measure_valid <= 1'b0;
      freq.in_range      <= 1'b0;
    end else begin
      freq.measure_valid <= win_end;
      if (win_end) begin
        freq.in_range <= (edges_tot > CW'(LO_EDG)) && (edges_tot < CW'(HI_EDG));
      end
    end
  end
endmodule
`default_nettype wire

// file: tb/tb_transceiver_status_one.sv
/*
  Self-checking bench of the transceiver status block.
  Assumes the design files compiled first and a shortened carrier window.
*/
`include "ts1_params.svh"
`default_nettype none
module tb_transceiver_status_one import ts1_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] A_ST = 8'h1C, A_THR = 8'h40, A_CEN = 8'h44, A_MEN = 8'h48;
  localparam logic [7:0] A_CTL = 8'h4C, A_ERR = 8'h50, A_EVS = 8'h54, A_EVM = 8'h58;
  localparam logic [4:0] P_FLD = 5'h10, P_CST = 5'h08, P_CFN = 5'h04;
  localparam logic [4:0] P_RXF = 5'h02, P_RXS = 5'h01;
  typedef struct packed {
    logic [5:0] thr; logic [6:0] fill; logic fld; logic tmr;
    logic [6:0] cs; logic [6:0] ce; logic [4:0] ms; logic [4:0] me; logic [4:0] exp;
  } ts1_row_s;
  logic        mclk, rst, psel, penable, pwrite, pready, pslverr, car;
  logic [7:0]  paddr, status;
  logic [31:0] pwdata, prdata, r;
  logic        c_start, c_cmd, c_fin, c_rz, tmr, fld, rx_start, rx_fail, ck_fail, irq, e;
  logic [6:0]  cs, fill;
  logic [4:0]  ms;
  int          n_mismatch, cmp_count, car_half, car_cnt;
  ts1_row_s    rows [7];

  ts1_status_one #(.WIN_NS(2000)) dut (
    .i_mclk(mclk), .i_rst(rst), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata),
    .o_pslverr(pslverr), .i_rx_carrier(car), .i_crc_start(c_start),
    .i_crc_compute_cmd(c_cmd), .i_crc_finish(c_fin), .i_crc_residue_zero(c_rz),
    .i_comm_irq_src(cs), .i_misc_irq_src(ms), .i_timer_enabled(tmr),
    .i_field_detect(fld), .i_fifo_fill_count(fill), .i_rx_start(rx_start),
    .i_rx_crc_fail(rx_fail), .o_status_one(status), .o_checksum_check_failed(ck_fail),
    .o_irq(irq));

  always #10 mclk = ~mclk;

  // Carrier made on the system clock, half period in cycles, 0 holds it low
  always @(posedge mclk) begin
    if (car_half == 0) begin
      car     <= 1'b0;
      car_cnt <= 0;
    end else if (car_cnt >= car_half - 1) begin
      car     <= ~car;
      car_cnt <= 0;
    end else begin
      car_cnt <= car_cnt + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask

  task pulse(input logic [4:0] m);
    @(posedge mclk);
    {fld, c_start, c_fin, rx_fail, rx_start} <= {fld, c_start, c_fin, rx_fail, rx_start} | m;
    @(posedge mclk);
    {fld, c_start, c_fin, rx_fail, rx_start} <= {fld, c_start, c_fin, rx_fail, rx_start} & ~m;
    tick(3);
  endtask

  task finish_test;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    tick(20000);
    n_mismatch++;
    finish_test;
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 0; rst = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
    c_start = 0; c_cmd = 0; c_fin = 0; c_rz = 0; tmr = 0; fld = 0; rx_start = 0;
    rx_fail = 0; cs = 0; ms = 0; fill = 0; car_half = 0; n_mismatch = 0; cmp_count = 0;
    // Expected {irq, timer, field, nearly-full, nearly-empty}
    rows[0] = {6'd4, 7'd60, 1'b1, 1'b0, 7'h01, 7'h01, 5'h00, 5'h00, 5'b10110};
    rows[1] = {6'd4, 7'd59, 1'b0, 1'b1, 7'h01, 7'h00, 5'h00, 5'h00, 5'b01000};
    rows[2] = {6'd4, 7'd4,  1'b0, 1'b0, 7'h00, 7'h00, 5'h10, 5'h10, 5'b10001};
    rows[3] = {6'd4, 7'd5,  1'b0, 1'b0, 7'h40, 7'h3F, 5'h0F, 5'h10, 5'b00000};
    rows[4] = {6'd0, 7'd64, 1'b1, 1'b1, 7'h00, 7'h00, 5'h00, 5'h00, 5'b01110};
    rows[5] = {6'd63, 7'd0, 1'b0, 1'b0, 7'h00, 7'h00, 5'h00, 5'h00, 5'b00001};
    rows[6] = {6'd63, 7'd1, 1'b0, 1'b0, 7'h00, 7'h00, 5'h00, 5'h00, 5'b00011};
    tick(2);
    chk({24'h0, status & 8'h76}, 32'h42, "reset value");
    tick(14);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b1, A_THR, {26'h0, rows[i].thr});
      apb(1'b1, A_CEN, {25'h0, rows[i].ce});
      apb(1'b1, A_MEN, {27'h0, rows[i].me});
      fill <= rows[i].fill; fld <= rows[i].fld; tmr <= rows[i].tmr;
      cs <= rows[i].cs; ms <= rows[i].ms;
      tick(3);
      chk({27'h0, status[4:0]}, {27'h0, rows[i].exp}, "row flags");
      apb(1'b0, A_ST, 32'h0);
      chk({27'h0, r[4:0]}, {27'h0, rows[i].exp}, "row read");
    end
    // Status one ignores writes; unmapped and unaligned places refused
    apb(1'b1, A_ST, 32'hFF);
    apb(1'b0, A_ST, 32'h0);
    chk(r, 32'h43, "write ignored");
    apb(1'b0, 8'hFC, 32'h0);
    chk({31'h0, e}, 32'h1, "unmapped");
    apb(1'b0, 8'h1D, 32'h0);
    chk({31'h0, e}, 32'h1, "unaligned");
    // Field event raised, masked, cleared
    fld <= 1'b0;
    apb(1'b1, A_EVS, 32'hF);
    apb(1'b1, A_EVM, 32'h1);
    chk({31'h0, irq}, 32'h0, "irq idle");
    pulse(P_FLD);
    fld <= 1'b1;
    tick(3);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, A_EVM, 32'h0);
    tick(2);
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, A_EVM, 32'h1);
    apb(1'b1, A_EVS, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // Checksum co-processor
    c_cmd <= 1'b1;
    pulse(P_CST);
    chk({30'h0, status[6:5]}, 32'h0, "crc busy");
    c_rz <= 1'b1;
    pulse(P_CFN);
    chk({30'h0, status[6:5]}, 32'h3, "crc good");
    c_cmd <= 1'b0;
    c_rz <= 1'b0;
    pulse(P_CST);
    pulse(P_CFN);
    chk({30'h0, status[6:5]}, 32'h0, "crc nonzero");
    // Receive checksum error flag
    pulse(P_RXF);
    chk({31'h0, ck_fail}, 32'h0, "fail disabled");
    apb(1'b1, A_CTL, 32'h1);
    pulse(P_RXF);
    apb(1'b0, A_ERR, 32'h0);
    chk(r, 32'h1, "fail set");
    pulse(P_RXS);
    chk({31'h0, ck_fail}, 32'h0, "fail cleared");
    // Carrier: 25 edges per window in band, 50 out of band
    car_half <= 2;
    tick(250);
    chk({31'h0, status[7]}, 32'h1, "freq in band");
    car_half <= 1;
    tick(250);
    chk({31'h0, status[7]}, 32'h0, "freq too high");
    car_half <= 0;
    tick(250);
    chk({31'h0, status[7]}, 32'h0, "no carrier");
    // Mid-run reset returns flags, configuration and sticky state
    pulse(P_RXF);
    chk({31'h0, ck_fail}, 32'h1, "fail before reset");
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    chk({24'h0, status & 8'h76}, 32'h42, "reset value mid-run");
    chk({30'h0, ck_fail, irq}, 32'h0, "sticky after reset");
    apb(1'b0, A_THR, 32'h0);
    chk(r, 32'h0, "threshold after reset");
    finish_test;
  end
endmodule
`default_nettype wire
